/* inc/adc_seq_cfg.svh */
`ifndef ADC_SEQ_CFG_SVH
`define ADC_SEQ_CFG_SVH

// ----------------------------------------
// Control word field positions
// ----------------------------------------
`define CW_RANGE_BIT   0
`define CW_SEQ_BIT     1
`define CW_MASK_BIT    2
`define CW_MODE_LO     3
`define CW_MODE_HI     4
`define CW_CHAN_LO     5
`define CW_CHAN_HI     7
`define CW_REF_BIT     8
`define CW_CODING_BIT  9
`define CW_PM_LO       10
`define CW_PM_HI       11

// ----------------------------------------
// Reset values and mask write count
// ----------------------------------------
`define MASK_RESET     8'h00
`define CHAN_RESET     3'h0
`define CTRL_RESET     12'h000
`define WRITES_IN_MASK 2'h2

// ----------------------------------------
// Result widths
// ----------------------------------------
`define RES_BITS_12    12
`define RES_BITS_10    10

`endif

/* inc/adc_seq_pkg.sv */
package adc_seq_pkg;

  typedef enum logic [1:0] {
    MODE_SINGLE,
    MODE_MASK_LOAD,
    MODE_KEEP,
    MODE_CONSEC
  } seq_mode_t;

  typedef struct packed {
    logic [1:0] power_mode;
    logic       coding;
    logic       ref_sel;
    logic [2:0] channel_select_field;
    logic [1:0] input_mode;
    logic       mask_select;
    logic       sequence_enable;
    logic       range;
  } ctrl_word_t;

  typedef struct packed {
    logic [2:0] channel;
    logic       coding;
    logic       range;
    logic       ref_sel;
    logic [1:0] input_mode;
    logic [1:0] power_mode;
  } conv_setup_t;

endpackage : adc_seq_pkg

/* hdl/edge_sync.sv */
// Two-stage synchroniser followed by rise/fall detection on the second stage
module edge_sync (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // Pin side
  input  wire logic pin_in,
  // Synchronised outputs
  output logic      level,
  output logic      rise,
  output logic      fall
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } sync_state_t;

  sync_state_t st_r;
  sync_state_t st_nxt;

  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = pin_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
  end

  // Idle high matches an unasserted active-low strobe
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r <= 3'h7;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level = st_r.s2;
  assign rise  = st_r.s2 & ~st_r.s3;
  assign fall  = ~st_r.s2 & st_r.s3;

endmodule : edge_sync

/* hdl/adc_channel_sequencer.sv */
`include "adc_seq_cfg.svh"

// Overview of operation
// - Seq 0, mask 0: convert last written channel
// - Seq 0, mask 1: next two writes load mask
// - Seq 1, mask 0: update settings, keep sequence
// - Seq 1, mask 1: run channels 0 to selected
// - Mask is eight bits, taken on write rise
// - Mask write keeps only low eight bits
// - Mask write only after 0,1 control write
// - Mask bit n selects channel n
// - Ascending selected channels, advance per start, wrap
// - Control write other than 1,0 ends mask run
// - Code steps 4096 or 1024 across span
// - Coding 0 two's complement, 1 straight binary
// - Channel select field is bits 7 to 5
// - Mask select bit 2, sequence enable bit 1
module adc_channel_sequencer (
  // Clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  // Parallel host bus (pins)
  input  wire logic [11:0]               data_bus,
  input  wire logic                      write_n,
  input  wire logic                      conversion_start_n,
  // Conversion set-up for the converter core
  output adc_seq_pkg::conv_setup_t       conv_setup,
  output logic                           conv_start,
  output adc_seq_pkg::seq_mode_t         seq_mode,
  output logic [7:0]                     channel_mask,
  output logic                           mask_pending,
  // Raw result from the converter core, coded here
  input  wire logic                      raw_valid,
  input  wire logic [11:0]               raw_result,
  input  wire logic                      ten_bit_variant,
  output logic [11:0]                    coded_result,
  output logic                           coded_valid
);

  import adc_seq_pkg::*;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic wr_rise;
  logic cs_fall;
  logic [11:0] bus_s1_r;
  logic [11:0] bus_s2_r;

  // Write strobe: the word is taken on its rising edge
  edge_sync u_wr_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pin_in  (write_n),
    .level   (),
    .rise    (wr_rise),
    .fall    ()
  );

  // Conversion start: the falling edge launches a conversion
  edge_sync u_cs_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pin_in  (conversion_start_n),
    .level   (),
    .rise    (),
    .fall    (cs_fall)
  );

  // Data is stable around the strobe edge; two stages keep it aligned with it
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bus_s1_r <= 12'h000;
      bus_s2_r <= 12'h000;
    end else begin
      bus_s1_r <= data_bus;
      bus_s2_r <= bus_s1_r;
    end
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    ctrl_word_t   ctrl;
    seq_mode_t    mode;
    logic [7:0]   mask;
    // Mask words still owed after a 0,1 control write
    logic [1:0]   mask_writes_left;
    logic         mask_pend;
    // Last channel started; 7 makes the next mask step start lowest
    logic [2:0]   chan;
    // A mask or consecutive run is active
    logic         running;
    conv_setup_t  setup;
    logic         start;
    logic [11:0]  result;
    logic         result_valid;
  } seq_state_t;

  seq_state_t st_r;
  seq_state_t st_nxt;

  ctrl_word_t  wr_word;
  logic [2:0]  next_masked;
  logic        mask_has_bits;
  logic [2:0]  first_masked;
  logic [11:0] sign_flip;
  logic [11:0] width_mask;
  logic [2:0]  consec_next;
  logic        mask_armed;
  logic [1:0]  mode_bits;

  assign wr_word = ctrl_word_t'(bus_s2_r);

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  // armed count routes words
  // Routing follows the count, not the word, so mask data never decodes as control
  assign mask_armed = st_r.mask_writes_left != 2'h0;
  assign mode_bits  = {wr_word.sequence_enable, wr_word.mask_select};

  // ----------------------------------------
  // Mask search helpers
  // ----------------------------------------
  // bit is channel
  // ascending wrap search
  // Lowest set bit first, then the lowest one above the current channel
  always_comb begin
    next_masked   = st_r.chan;
    first_masked  = 3'h0;
    mask_has_bits = |st_r.mask;
    for (int i = 7; i >= 0; i--) begin
      if (st_r.mask[i]) begin
        first_masked = 3'(i);
      end
    end
    next_masked = first_masked;
    for (int i = 7; i >= 0; i--) begin
      if (st_r.mask[i] && (3'(i) > st_r.chan)) begin
        next_masked = 3'(i);
      end
    end
  end

  // coding
  // Two's complement is offset binary with the top bit inverted
  always_comb begin
    sign_flip = 12'h000;
    if (ten_bit_variant) begin
      sign_flip[`RES_BITS_10-1] = 1'b1;
    end else begin
      sign_flip[`RES_BITS_12-1] = 1'b1;
    end
  end

  // ten-bit code range
  // Bits above the ten-bit range are cleared so a stray core bit cannot leave it
  always_comb begin
    width_mask = 12'hFFF;
    if (ten_bit_variant) begin
      width_mask = 12'h3FF;
    end
  end

  // ----------------------------------------
  // Consecutive run step
  // ----------------------------------------
  // step, wrap to zero
  // A final channel lowered mid-run wraps at once instead of running past it
  always_comb begin
    consec_next = st_r.chan + 3'h1;
    if (st_r.chan >= st_r.ctrl.channel_select_field) begin
      consec_next = 3'h0;
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_nxt              = st_r;
    // Start and result strobes are one-cycle pulses
    st_nxt.start        = 1'b0;
    st_nxt.result_valid = 1'b0;

    if (wr_rise) begin
      if (mask_armed) begin
        st_nxt.mask             = bus_s2_r[7:0];
        st_nxt.mask_writes_left = st_r.mask_writes_left - 2'h1;
        st_nxt.running          = 1'b1;
        st_nxt.mode             = MODE_MASK_LOAD;
        // Sequence restarts at lowest selected channel
        st_nxt.chan             = 3'h7;
      end else begin
        st_nxt.ctrl = wr_word;
        unique case (mode_bits)
          2'b00: begin
            st_nxt.mode    = MODE_SINGLE;
            st_nxt.running = 1'b0;
            st_nxt.chan    = wr_word.channel_select_field;
          end
          2'b01: begin
            st_nxt.mode             = MODE_SINGLE;
            st_nxt.running          = 1'b0;
            st_nxt.mask_writes_left = `WRITES_IN_MASK;
          end
          2'b10: begin
            st_nxt.mode = st_r.mode;
          end
          2'b11: begin
            st_nxt.mode    = MODE_CONSEC;
            st_nxt.running = 1'b1;
            st_nxt.chan    = wr_word.channel_select_field;
          end
        endcase
      end
    end

    // A start in the same cycle as a write uses the settings before it
    if (cs_fall) begin
      st_nxt.start = 1'b1;
      st_nxt.setup.coding     = st_r.ctrl.coding;
      st_nxt.setup.range      = st_r.ctrl.range;
      st_nxt.setup.ref_sel    = st_r.ctrl.ref_sel;
      st_nxt.setup.input_mode = st_r.ctrl.input_mode;
      st_nxt.setup.power_mode = st_r.ctrl.power_mode;
      if (st_r.running && st_r.mode == MODE_MASK_LOAD) begin
        if (mask_has_bits) begin
          st_nxt.setup.channel = next_masked;
          st_nxt.chan          = next_masked;
        end else begin
          st_nxt.setup.channel = st_r.chan;
        end
      end else if (st_r.running && st_r.mode == MODE_CONSEC) begin
        st_nxt.chan          = consec_next;
        st_nxt.setup.channel = consec_next;
      end else begin
        st_nxt.setup.channel = st_r.ctrl.channel_select_field;
      end
    end

    if (raw_valid) begin
      st_nxt.result_valid = 1'b1;
      // coding select
      // Coding follows the set-up the conversion was started with
      st_nxt.result = (raw_result & width_mask) ^ (st_r.setup.coding ? 12'h000 : sign_flip);
    end

    st_nxt.mask_pend = st_nxt.mask_writes_left != 2'h0;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r.ctrl             <= ctrl_word_t'(`CTRL_RESET);
      st_r.mode             <= MODE_SINGLE;
      st_r.mask             <= `MASK_RESET;
      st_r.mask_writes_left <= 2'h0;
      st_r.mask_pend        <= 1'b0;
      st_r.chan             <= `CHAN_RESET;
      st_r.running          <= 1'b0;
      st_r.setup            <= '0;
      st_r.start            <= 1'b0;
      st_r.result           <= 12'h000;
      st_r.result_valid     <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Every output is a register field, so the core sees no decode glitches
  assign conv_setup   = st_r.setup;
  assign conv_start   = st_r.start;
  assign seq_mode     = st_r.mode;
  assign channel_mask = st_r.mask;
  assign mask_pending = st_r.mask_pend;
  assign coded_result = st_r.result;
  assign coded_valid  = st_r.result_valid;

endmodule : adc_channel_sequencer

/* dv/adc_seq_assertions.sv */
module adc_seq_assertions (
  // Clock and reset
  input wire logic                     sys_clk,
  input wire logic                     rst,
  // Pins
  input wire logic [11:0]              data_bus,
  input wire logic                     write_n,
  input wire logic                     conversion_start_n,
  // Core side
  input wire adc_seq_pkg::conv_setup_t conv_setup,
  input wire logic                     conv_start,
  input wire adc_seq_pkg::seq_mode_t   seq_mode,
  input wire logic [7:0]               channel_mask,
  input wire logic                     mask_pending,
  input wire logic                     raw_valid,
  input wire logic [11:0]              raw_result,
  input wire logic                     ten_bit_variant,
  input wire logic [11:0]              coded_result,
  input wire logic                     coded_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  import adc_seq_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  AST_RESET_STATE: assert property ($past(rst) |-> seq_mode == MODE_SINGLE
    && channel_mask == 8'h00) else $error("state after reset wrong");
  AST_START_LAT: assert property ($fell(conversion_start_n) |-> ##[3:5] conv_start)
    else $error("start edge not answered");
  AST_START_PULSE: assert property (conv_start |=> !conv_start)
    else $error("start pulse too long");
  AST_SETUP_HOLD: assert property (!conv_start |-> $stable(conv_setup))
    else $error("setup moved without start");
  AST_CODE_LAT: assert property (raw_valid |=> coded_valid)
    else $error("coded result missing");
  AST_CODE_CAUSE: assert property (coded_valid |-> $past(raw_valid))
    else $error("coded result without raw");
  AST_CODING: assert property (coded_valid |-> coded_result ==
    (($past(raw_result) & ($past(ten_bit_variant) ? 12'h3FF : 12'hFFF)) ^
    ($past(conv_setup.coding) ? 12'h000 : $past(ten_bit_variant) ? 12'h200 : 12'h800)))
    else $error("coding wrong");
  AST_MASK_SRC: assert property ($changed(channel_mask) |-> $past(mask_pending))
    else $error("mask changed by control write");
  AST_MASK_CHAN: assert property (conv_start && seq_mode == MODE_MASK_LOAD
    && channel_mask != 8'h00 |-> channel_mask[conv_setup.channel])
    else $error("channel outside mask");
endmodule : adc_seq_assertions

/* dv/host_bus.sv */
module host_bus (
  // Clock
  input wire logic sys_clk,
  // Pins
  output logic [11:0] data_bus,
  output logic        write_n,
  output logic        conversion_start_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    data_bus = 12'h000;
    write_n = 1'b1;
    conversion_start_n = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  // word held round the rising strobe
  task automatic wr(input logic [11:0] w);
    tick(1);
    data_bus = w;
    tick(3);
    write_n = 1'b0;
    tick(3);
    write_n = 1'b1;
    tick(2);
    // Released bus shows the inverse so a late sample is caught
    data_bus = ~w;
    tick(4);
  endtask : wr
  task automatic start;
    conversion_start_n = 1'b0;
    tick(3);
    conversion_start_n = 1'b1;
    tick(3);
  endtask : start
endmodule : host_bus

/* dv/test_adc_channel_sequencer.sv */
module test_adc_channel_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  import adc_seq_pkg::*;
  logic sys_clk = 0, rst = 1, raw_valid = 0, ten_bit_variant = 0;
  logic [11:0] raw_result = 12'h000, coded_result, data_bus;
  logic write_n, conversion_start_n, conv_start, mask_pending, coded_valid;
  conv_setup_t conv_setup;
  seq_mode_t seq_mode;
  logic [7:0] channel_mask;
  int fails = 0, compares = 0;
  always #2.5 sys_clk = ~sys_clk;
  host_bus u_host_bus (
    .sys_clk            (sys_clk),
    .data_bus           (data_bus),
    .write_n            (write_n),
    .conversion_start_n (conversion_start_n)
  );
  adc_channel_sequencer u_adc_channel_sequencer (
    .sys_clk            (sys_clk),
    .rst                (rst),
    .data_bus           (data_bus),
    .write_n            (write_n),
    .conversion_start_n (conversion_start_n),
    .conv_setup         (conv_setup),
    .conv_start         (conv_start),
    .seq_mode           (seq_mode),
    .channel_mask       (channel_mask),
    .mask_pending       (mask_pending),
    .raw_valid          (raw_valid),
    .raw_result         (raw_result),
    .ten_bit_variant    (ten_bit_variant),
    .coded_result       (coded_result),
    .coded_valid        (coded_valid)
  );
  // ------
  // Helpers
  // ------
  function automatic logic [11:0] cw(logic cd, logic [2:0] ch, logic m, logic s);
    return {2'b11, cd, 1'b0, ch, 2'b00, m, s, 1'b0};
  endfunction : cw
  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic await(input bit cv);
    for (int i = 0; i < 10 && (cv ? coded_valid : conv_start) !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
  endtask : await
  task automatic conv(input logic [2:0] ch);
    fork
      u_host_bus.start();
    join_none
    await(0);
    chk("channel", {9'h001, ch}, {8'h00, conv_start, conv_setup.channel});
    wait fork;
  endtask : conv
  task automatic code(input logic [11:0] r, input logic [11:0] e);
    raw_result = r;
    raw_valid = 1'b1;
    u_host_bus.tick(1);
    raw_valid = 1'b0;
    await(1);
    chk("valid", 12'h001, {11'h000, coded_valid});
    chk("coded", e, coded_result);
  endtask : code
  task automatic tally_and_finish;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  // ------
  // Tests
  // ------
  initial begin
    repeat (6) @(posedge sys_clk);
    #1 rst = 1'b0;
    u_host_bus.tick(4);
    chk("reset", 12'h000, {2'b00, seq_mode, channel_mask});
    conv(3'h0);
    u_host_bus.wr(cw(0, 3'h5, 0, 0));
    conv(3'h5);
    chk("setup", 12'h283, {2'b00, conv_setup});
    conv(3'h5);
    u_host_bus.wr(cw(0, 3'h0, 1, 0));
    chk("pending", 12'h001, {11'h000, mask_pending});
    u_host_bus.wr(12'hF25);
    chk("mask", 12'h025, {4'h0, channel_mask});
    u_host_bus.wr(12'h0A6);
    chk("mask", 12'h0A6, {3'h0, mask_pending, channel_mask});
    chk("mode", 12'h001, {10'h000, seq_mode});
    conv(3'h1);
    conv(3'h2);
    u_host_bus.wr(cw(1, 3'h3, 0, 1));
    chk("mode", 12'h001, {10'h000, seq_mode});
    conv(3'h5);
    conv(3'h7);
    conv(3'h1);
    u_host_bus.wr(cw(0, 3'h6, 0, 0));
    chk("mode", 12'h000, {10'h000, seq_mode});
    conv(3'h6);
    chk("mask", 12'h0A6, {4'h0, channel_mask});
    code(12'h800, 12'h000);
    ten_bit_variant = 1'b1;
    code(12'h200, 12'h000);
    u_host_bus.wr(cw(1, 3'h2, 1, 1));
    chk("mode", 12'h003, {10'h000, seq_mode});
    for (int i = 0; i < 4; i++) conv(3'(i % 3));
    code(12'h155, 12'h155);
    tally_and_finish();
  end
  initial begin
    #50us;
    fails++;
    tally_and_finish();
  end
endmodule : test_adc_channel_sequencer

bind adc_channel_sequencer adc_seq_assertions u_adc_seq_assertions (
  .sys_clk            (sys_clk),
  .rst                (rst),
  .data_bus           (data_bus),
  .write_n            (write_n),
  .conversion_start_n (conversion_start_n),
  .conv_setup         (conv_setup),
  .conv_start         (conv_start),
  .seq_mode           (seq_mode),
  .channel_mask       (channel_mask),
  .mask_pending       (mask_pending),
  .raw_valid          (raw_valid),
  .raw_result         (raw_result),
  .ten_bit_variant    (ten_bit_variant),
  .coded_result       (coded_result),
  .coded_valid        (coded_valid)
);
